// ==== dly_dev.sv ====
/*
 * Device end: shift register, active setting, serial output.
 * Assumes link pins are asynchronous to clk; two-flop synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

module dly_dev (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	dly_if.dev                    link,
	output var  logic [7:0]       setting,
	output var  logic             setting_new
);
	import dly_pkg::*;

	typedef struct packed {
		logic [1:0] en_s;
		logic [1:0] sck_s;
		logic [1:0] sdi_s;
		logic       en_d;
		logic       sck_d;
		logic [7:0] shift;
		logic [7:0] active;
		logic       loaded;
		logic       q;
		logic       q_oe;
	} dev_s;

	dev_s st_r;
	dev_s st_nxt;

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic en_now;
		logic sck_now;
		en_now  = 1'b0;
		sck_now = 1'b0;
		st_nxt  = st_r;
		// Two-flop synchronisers; only the second stage is read downstream
		st_nxt.en_s  = {st_r.en_s[0], link.en};
		st_nxt.sck_s = {st_r.sck_s[0], link.sck};
		st_nxt.sdi_s = {st_r.sdi_s[0], link.sdi};
		en_now       = st_r.en_s[1];
		sck_now      = st_r.sck_s[1];
		st_nxt.en_d  = en_now;
		st_nxt.sck_d = sck_now;
		st_nxt.loaded = 1'b0;
		// Shift on rising serial clock while enabled, MSB enters first
		if (en_now && sck_now && !st_r.sck_d) begin
			st_nxt.shift = {st_r.shift[6:0], st_r.sdi_s[1]};
		end
		// Falling enable commits the word; setting untouched otherwise
		if (!en_now && st_r.en_d) begin
			st_nxt.active = st_r.shift;
			st_nxt.loaded = 1'b1;
		end
		// Top bit of shift register leaves on the serial output
		st_nxt.q    = st_nxt.shift[7];
		st_nxt.q_oe = en_now;
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs; setting is the step index 0..STEP_MAX of the delay path
	assign link.sdo     = st_r.q;
	assign link.sdo_oe  = st_r.q_oe;
	assign setting      = st_r.active;
	assign setting_new  = st_r.loaded;
endmodule
`default_nettype wire

// ==== dly_host.sv ====
/*
 * Host end: generates enable, serial clock and data by divider.
 * Shifts NDEV words (chain), optionally writes back read data.
 */
`timescale 1ns/1ps
`default_nettype none
module dly_host #(
	parameter int NDEV        = 1,
	parameter int SETTLE_CNT  = dly_pkg::SETTLE_CYC
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	dly_if.host                   link,
	input  wire logic             start,
	input  wire logic             readback,
	input  wire logic [7:0]       wr_data,
	output var  logic             busy,
	output var  logic [7:0]       rd_data,
	output var  logic             done
);
	import dly_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LOW    = 3'b001,
		ST_HIGH   = 3'b010,
		ST_END    = 3'b011,
		ST_SETTLE = 3'b100
	} hst_e;

	typedef struct packed {
		hst_e             state;
		logic [1:0]       q_s;
		logic [7:0]       div;
		logic [7:0]       bits;
		logic [7:0]       words;
		logic [CNT_W-1:0] wait_c;
		logic [7:0]       data;
		logic [7:0]       rd;
		logic             rb;
		logic             en;
		logic             sck;
		logic             sdi;
		logic             busy;
		logic             done;
	} host_s;

	host_s st_r;
	host_s st_nxt;

	////////////////////////////////////////////////////////////////////
	// Sequencer: one full word per chained device, MSB first
	always_comb begin
		st_nxt      = st_r;
		st_nxt.q_s  = {st_r.q_s[0], link.sdo};
		st_nxt.done = 1'b0;
		unique case (st_r.state)
			ST_IDLE: begin
				if (start) begin
					st_nxt.state = ST_LOW;
					st_nxt.en    = 1'b1;
					st_nxt.busy  = 1'b1;
					st_nxt.rb    = readback;
					st_nxt.data  = wr_data;
					st_nxt.bits  = '0;
					st_nxt.words = '0;
					st_nxt.div   = '0;
				end
			end
			ST_LOW: begin
				// Present data; on readback return the sampled output
				st_nxt.sdi = st_r.rb ? st_r.q_s[1] : st_r.data[7];
				st_nxt.div = st_r.div + 8'h01;
				if (st_r.div == SCK_HALF_CYC) begin
					st_nxt.div   = '0;
					st_nxt.sck   = 1'b1;
					st_nxt.rd    = {st_r.rd[6:0], st_r.q_s[1]};
					st_nxt.data  = {st_r.data[6:0], st_r.data[7]};
					st_nxt.state = ST_HIGH;
				end
			end
			ST_HIGH: begin
				st_nxt.div = st_r.div + 8'h01;
				if (st_r.div == SCK_HALF_CYC) begin
					st_nxt.div   = '0;
					st_nxt.sck   = 1'b0;
					st_nxt.bits  = st_r.bits + 8'h01;
					st_nxt.state = ST_LOW;
					if (st_r.bits == BITS_W - 8'h01) begin
						st_nxt.bits  = '0;
						st_nxt.words = st_r.words + 8'h01;
						if (st_r.words == 8'(NDEV - 1)) begin
							st_nxt.state = ST_END;
						end
					end
				end
			end
			ST_END: begin
				st_nxt.div = st_r.div + 8'h01;
				if (st_r.div == SCK_HALF_CYC) begin
					st_nxt.en     = 1'b0;
					st_nxt.wait_c = '0;
					st_nxt.state  = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				st_nxt.wait_c = st_r.wait_c + 16'h0001;
				if (st_r.wait_c == CNT_W'(SETTLE_CNT)) begin
					st_nxt.state = ST_IDLE;
					st_nxt.busy  = 1'b0;
					st_nxt.done  = 1'b1;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.en  = st_r.en;
	assign link.sck = st_r.sck;
	assign link.sdi = st_r.sdi;
	assign busy     = st_r.busy;
	assign rd_data  = st_r.rd;
	assign done     = st_r.done;
endmodule
`default_nettype wire

// ==== dly_if.sv ====
/*
 * Three-wire link between host and delay device.
 * Q is a tristate pin: carried as data plus output enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface dly_if;
	logic en;
	logic sck;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	modport dev  (input en, input sck, input sdi, output sdo, output sdo_oe);
	modport host (output en, output sck, output sdi, input sdo, input sdo_oe);
endinterface
`default_nettype wire

// ==== dly_pkg.sv ====
/*
 * Shared constants for the three-wire delay-setting port and its host.
 * Assumes a 200 MHz system clock on both ends; serial clock is sampled.
 */
`default_nettype none
package dly_pkg;
	localparam int          SET_W        = 8;
	localparam logic [7:0]  SET_RST      = 8'h00;
	localparam int          CLK_NS       = 5;
	// Host serial clock half period, stays under 10 MHz with margin
	localparam int          SCK_HALF_NS  = 80;
	localparam logic [7:0]  SCK_HALF_CYC = 8'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
	// Enable-to-delay settling after the load edge
	localparam int          SETTLE_US    = 50;
	localparam int          SETTLE_CYC   = (SETTLE_US * 1000) / CLK_NS;
	localparam int          CNT_W        = 16;
	localparam logic [7:0]  BITS_W       = 8'(SET_W);
	// Highest delay step index
	localparam logic [7:0]  STEP_MAX     = 8'hFF;
endpackage
`default_nettype wire

// ==== dly_props.sv ====
/* Link checker for the delay-setting port.
   Assumes one host and one device sharing a dly_if on clk. */
`timescale 1ns/1ps
`default_nettype none
module dly_props #(
	parameter int NDEV = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic en,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic       sck_r;
	logic [7:0] bits_r;
	////////////////////////////////////////////////////////////////
	// Count serial clock rises within one enable frame
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_r <= 1'b0;
			bits_r <= 8'h00;
		end else begin
			sck_r <= sck;
			bits_r <= !en ? 8'h00 : bits_r + 8'(sck && !sck_r);
		end
	end
	sequence s_shift_held;
		(en && sck)[*8];
	endsequence
	sequence s_idle;
		(!en)[*8];
	endsequence
	property p_oe_on;    $rose(en) |-> ##[1:6] sdo_oe;           endproperty
	property p_oe_off;   $fell(en) |-> ##[1:6] !sdo_oe;          endproperty
	property p_oe_idle;  s_idle |-> !sdo_oe;                      endproperty
	property p_idle_sdo; s_idle |-> $stable(sdo);                 endproperty
	property p_held_sdo; s_shift_held |-> $stable(sdo);           endproperty
	property p_sck_en;   $rose(sck) |-> en;                        endproperty
	property p_count;    $fell(en) |-> bits_r == 8'(8 * NDEV);   endproperty
	property p_sdi_set;  $rose(sck) |-> $stable(sdi);             endproperty
	a_oe_on:    assert property (p_oe_on) else $error("oe late on");
	a_oe_off:   assert property (p_oe_off) else $error("oe late off");
	a_oe_idle:  assert property (p_oe_idle) else $error("oe while idle");
	a_idle_sdo: assert property (p_idle_sdo) else $error("sdo moved idle");
	a_held_sdo: assert property (p_held_sdo) else $error("sdo moved");
	a_sck_en:   assert property (p_sck_en) else $error("sck without en");
	a_count:    assert property (p_count) else $error("bad bit count");
	a_sdi_set:  assert property (p_sdi_set) else $error("sdi moved");
endmodule
`default_nettype wire

// ==== test_delay_setting_serial_port.sv ====
/* Bench joining host and device ends through dly_if.
   Assumes package, interface and both ends compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module test_delay_setting_serial_port;
	import dly_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       start = 1'b0;
	logic       readback = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic       busy;
	logic       done;
	logic       setting_new;
	logic [7:0] rd_data;
	logic [7:0] setting;
	logic [7:0] exp_set;
	int         err_count = 0;
	int         checks_done = 0;
	int         commit_count = 0;
	logic [7:0] wr_t [7] = '{8'hA5, 8'h3C, 8'hFF, 8'hFF, 8'h00, 8'hC3, 8'h96};
	logic       rb_t [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
	logic [7:0] rd_t [7] = '{8'h00, 8'hA5, 8'h3C, 8'h3C, 8'hFF, 8'h00, 8'h00};
	dly_if link ();
	dly_host #(.NDEV(1), .SETTLE_CNT(20)) dly_host_i (.clk(clk), .sys_rst(sys_rst),
		.link(link), .start(start), .readback(readback), .wr_data(wr_data),
		.busy(busy), .rd_data(rd_data), .done(done));
	dly_dev dly_dev_i (.clk(clk), .sys_rst(sys_rst), .link(link), .setting(setting),
		.setting_new(setting_new));
	dly_props #(.NDEV(1)) dly_props_i (.clk(clk), .sys_rst(sys_rst), .en(link.en),
		.sck(link.sck), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
	////////////////////////////////////////////////////////////////
	// Clock generation
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Count commit pulses, sampled after they settle
	initial begin
		forever begin
			@(posedge clk) #1;
			if (setting_new === 1'b1) commit_count++;
		end
	end
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// One host access, waits for done under a bound
	task automatic access(input logic [7:0] w, input logic rb);
		@(posedge clk) #1;
		start = 1'b1;
		wr_data = w;
		readback = rb;
		@(posedge clk) #1;
		start = 1'b0;
		`CHK(busy, 1'b1)
		for (int i = 0; i < 4000; i++) begin
			@(posedge clk) #1;
			if (done === 1'b1) break;
		end
	endtask
	// Hang guard
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
	// Writes, read back and boundary words
	initial begin
		exp_set = SET_RST;
		repeat (5) @(posedge clk);
		#1 sys_rst = 1'b0;
		`CHK(setting, SET_RST)
		for (int t = 0; t < 7; t++) begin
			// Mid-run reset before the last word clears shift and setting
			if (t == 6) begin
				sys_rst = 1'b1;
				repeat (2) @(posedge clk) #1;
				sys_rst = 1'b0;
				exp_set = SET_RST;
				`CHK(setting, SET_RST)
			end
			access(wr_t[t], rb_t[t]);
			if (!rb_t[t]) exp_set = wr_t[t];
			`CHK(done, 1'b1)
			`CHK(busy, 1'b0)
			`CHK(commit_count, t + 1)
			`CHK(setting, exp_set)
			`CHK(rd_data, rd_t[t])
			$display("test %0d done", t);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
